// file: rtl/rsm_top.sv
// radio SPI master: SFR registers, byte queues and link crossing
`include "rsm_defs.svh"

module rsm_top
	import rsm_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic LINK_CLK,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	input wire logic [7:0] SFR_WDATA,
	output logic [7:0] SFR_RDATA,
	output logic IRQ,
	output logic RADIO_SCK,
	output logic RADIO_MOSI,
	input wire logic RADIO_MISO,
	output logic RADIO_CHIP_SELECT_N,
	output logic RADIO_CHIP_ENABLE,
	output logic RADIO_CLOCK_ENABLE_PIN
);
	// ****************************************
	// register state
	// ****************************************
	rsm_sfr_req_t req;
	rsm_flags_t fl;
	logic [6:0] cfg;
	logic [3:0] mask;
	logic [2:0] con;
	logic sel_cfg;
	logic sel_mask;
	logic sel_flags;
	logic sel_data;
	logic sel_con;

	assign req = '{addr: SFR_ADDR, wr: SFR_WR, rd: SFR_RD, wdata: SFR_WDATA};
	// the radio is reached only through these SFRs, no spare pins
	assign sel_cfg = (req.addr == `RSM_ADDR_CFG);
	assign sel_mask = (req.addr == `RSM_ADDR_MASK);
	assign sel_flags = (req.addr == `RSM_ADDR_FLAGS);
	assign sel_data = (req.addr == `RSM_ADDR_DATA);
	assign sel_con = (req.addr == `RSM_ADDR_CON);

	// ****************************************
	// queues and transfer control
	// ****************************************
	logic tx_ivalid;
	logic tx_iready;
	logic tx_ovalid;
	logic [7:0] tx_odata;
	logic rx_iready;
	logic rx_ovalid;
	logic rx_pop;
	logic [7:0] rx_odata;
	logic start;
	logic busy;
	logic req_tgl;
	logic [7:0] tx_hold;
	logic ack_tgl;
	logic [7:0] link_rx;
	logic a1;
	logic a2;
	logic a3;
	logic ack_seen;
	logic ack_evt;

	// writes to a full queue are dropped; software watches the space flag
	assign tx_ivalid = req.wr && sel_data;
	assign rx_pop = req.rd && sel_data && rx_ovalid;

	rsm_fifo2 #(.W(8), .D(2)) u_txq
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.in_valid(tx_ivalid),
		.in_ready(tx_iready),
		.in_data(req.wdata),
		.out_valid(tx_ovalid),
		.out_ready(start),
		.out_data(tx_odata)
	);

	rsm_fifo2 #(.W(8), .D(2)) u_rxq
	(
		.clk(REF_CLK),
		.nrst(NRST),
		.in_valid(ack_evt),
		.in_ready(rx_iready),
		.in_data(link_rx),
		.out_valid(rx_ovalid),
		.out_ready(rx_pop),
		.out_data(rx_odata)
	);

	// one byte in flight; a free rx slot at start stays free until the
	// answer, since only this logic fills the rx queue
	assign start = !busy && tx_ovalid && rx_iready;

	// ack sync: a1 feeds only a2
	assign ack_evt = (a2 == a3) && (a3 != ack_seen);

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			a1 <= 1'b0;
			a2 <= 1'b0;
			a3 <= 1'b0;
		end
		else
		begin
			a1 <= ack_tgl;
			a2 <= a1;
			a3 <= a2;
		end
	end

	// tx_hold stays put while busy, so the link may read it on its own
	// clock; the toggle crossing carries the only timing-critical bit
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			busy <= 1'b0;
			req_tgl <= 1'b0;
			tx_hold <= 8'h00;
			ack_seen <= 1'b0;
		end
		else
		begin
			if (start)
			begin
				busy <= 1'b1;
				req_tgl <= ~req_tgl;
				tx_hold <= tx_odata;
			end
			else if (ack_evt)
			begin
				// received byte of every exchange lands in rx queue
				busy <= 1'b0;
				ack_seen <= a3;
			end
		end
	end

	rsm_link u_link
	(
		.link_clk(LINK_CLK),
		.nrst(NRST),
		.req_tgl(req_tgl),
		.tx_byte(tx_hold),
		.ack_tgl(ack_tgl),
		.rx_byte(link_rx),
		.sck(RADIO_SCK),
		.mosi(RADIO_MOSI),
		.miso(RADIO_MISO)
	);

	// ****************************************
	// status flags and interrupt
	// ****************************************
	// pure levels from the queue state, nothing to acknowledge
	assign fl.rx_queue_full = !rx_iready;
	assign fl.rx_queue_has_byte = rx_ovalid;
	assign fl.tx_queue_empty = !tx_ovalid;
	assign fl.tx_queue_has_space = tx_iready;

	// registered so the pin cannot glitch while the queue levels settle;
	// costs one cycle of latency against the flags
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			IRQ <= 1'b0;
		else
			IRQ <= |(fl & ~mask);
	end

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			mask <= `RSM_RST_MASK;
		else if (req.wr && sel_mask)
			mask <= req.wdata[3:0];
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			cfg <= `RSM_RST_CFG;
		else if (req.wr && sel_cfg)
			cfg <= req.wdata[6:0];
	end

	// chip select starts high so no command is open after reset
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			con <= `RSM_RST_CON;
		else if (req.wr && sel_con)
			con <= req.wdata[2:0];
	end

	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			RADIO_CHIP_SELECT_N <= 1'b1;
			RADIO_CHIP_ENABLE <= 1'b0;
			RADIO_CLOCK_ENABLE_PIN <= 1'b0;
		end
		else
		begin
			RADIO_CHIP_SELECT_N <= con[`RSM_CON_CSN];
			RADIO_CHIP_ENABLE <= con[`RSM_CON_CE];
			RADIO_CLOCK_ENABLE_PIN <= con[`RSM_CON_RADIO_CLOCK_ENABLE_PIN];
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	// status has no write path; unmapped addresses read zero
	always_ff @(posedge REF_CLK or negedge NRST)
	begin
		if (!NRST)
			SFR_RDATA <= `RSM_RST_DATA;
		else if (req.rd)
		begin
			if (sel_cfg)
				SFR_RDATA <= {1'b0, cfg};
			else if (sel_mask)
				SFR_RDATA <= {4'h0, mask};
			else if (sel_flags)
				SFR_RDATA <= {4'h0, fl};
			else if (sel_data)
				SFR_RDATA <= rx_ovalid ? rx_odata : 8'h00;
			else if (sel_con)
				SFR_RDATA <= {5'h00, con};
			else
				SFR_RDATA <= 8'h00;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);

	a_irq_gating: assert property (
		##1 IRQ == $past(|(fl & ~mask)))
		else $error("irq does not match unmasked flags");
	a_mask_write: assert property (
		req.wr && sel_mask |=> mask == $past(req.wdata[3:0]))
		else $error("mask write lost");
	a_cfg_keep: assert property (
		req.rd && sel_cfg |=> SFR_RDATA[6:0] == $past(cfg))
		else $error("config read wrong");
	a_csn_pin: assert property (
		req.wr && sel_con |=> ##1 RADIO_CHIP_SELECT_N == $past(req.wdata[1], 2))
		else $error("chip select pin wrong");
	a_ce_pin: assert property (
		req.wr && sel_con |=> ##1 RADIO_CHIP_ENABLE == $past(req.wdata[0], 2))
		else $error("chip enable pin wrong");
	a_radio_clock_enable_pin_pin: assert property (
		req.wr && sel_con |=> ##1 RADIO_CLOCK_ENABLE_PIN == $past(req.wdata[2], 2))
		else $error("clock enable pin wrong");
	a_start_space: assert property (
		start |-> !fl.rx_queue_full ##1 (!start)[*2])
		else $error("start without rx space or twice");
	a_rx_avail: assert property (
		ack_evt |=> fl.rx_queue_has_byte)
		else $error("received byte not flagged");
	a_tx_flags: assert property (
		fl.tx_queue_empty |-> fl.tx_queue_has_space)
		else $error("empty tx queue shows no space");
	a_status_read: assert property (
		req.rd && sel_flags |=> SFR_RDATA == {4'h0, $past(fl)})
		else $error("status read wrong");


	// queue and transfer checks
	a_tx_push: assert property (
		req.wr && sel_data && fl.tx_queue_empty |=> !fl.tx_queue_empty)
		else $error("written byte not queued");
	a_empty_read: assert property (
		req.rd && sel_data && !fl.rx_queue_has_byte |=> SFR_RDATA == 8'h00)
		else $error("empty rx queue read not zero");
	a_rdata_hold: assert property (
		!req.rd |=> $stable(SFR_RDATA))
		else $error("read data changed without a read");
	a_rx_stall: assert property (
		fl.rx_queue_full |-> !start)
		else $error("byte started with rx queue full");
	a_rx_room: assert property (
		ack_evt |-> !fl.rx_queue_full)
		else $error("received byte found no room");
	// a byte needs about twenty link cycles; 600 leaves room for the sync
	a_byte_done: assert property (
		start |-> ##[1:600] ack_evt)
		else $error("byte never answered by the link");
	a_hold_steady: assert property (
		busy && $past(busy) |-> $stable(tx_hold))
		else $error("tx byte changed while in flight");
	a_rx_levels: assert property (
		fl.rx_queue_full |-> fl.rx_queue_has_byte)
		else $error("rx full without data flag");
	a_pop_space: assert property (
		req.rd && sel_data && fl.rx_queue_full |=> !fl.rx_queue_full)
		else $error("rx full flag did not clear on pop");
	a_con_reserved: assert property (
		req.rd && sel_con |=> SFR_RDATA[7:3] == 5'h00)
		else $error("control reserved bits not zero");

	// ****************************************
	// coverage
	// ****************************************
	c_round_trip: cover property (start ##[1:600] ack_evt);
	c_tx_full: cover property (!fl.tx_queue_has_space);
	c_rx_full: cover property (fl.rx_queue_full);
	c_irq: cover property (IRQ);
	c_stall: cover property (fl.rx_queue_full && !fl.tx_queue_empty);
endmodule

// file: rtl/rsm_defs.svh
// register map, field positions and reset values of the radio SPI master
`ifndef RSM_DEFS_SVH
`define RSM_DEFS_SVH
`define RSM_ADDR_CFG 8'hE4
`define RSM_ADDR_MASK 8'hE5
`define RSM_ADDR_FLAGS 8'hE6
`define RSM_ADDR_DATA 8'hE7
`define RSM_ADDR_CON 8'hE8
`define RSM_RST_CFG 7'h01
`define RSM_RST_MASK 4'hF
`define RSM_RST_FLAGS 4'h3
`define RSM_RST_DATA 8'h00
`define RSM_RST_CON 3'h2
`define RSM_CON_CE 0
`define RSM_CON_CSN 1
`define RSM_CON_RADIO_CLOCK_ENABLE_PIN 2
`define RSM_FLG_RX_FULL 3
`define RSM_FLG_RX_AVAIL 2
`define RSM_FLG_TX_EMPTY 1
`define RSM_FLG_TX_SPACE 0
`endif

// file: rtl/rsm_pkg.sv
// types shared by the radio SPI master files
package rsm_pkg;
	typedef struct packed
	{
		logic rx_queue_full;
		logic rx_queue_has_byte;
		logic tx_queue_empty;
		logic tx_queue_has_space;
	} rsm_flags_t;
	typedef struct packed
	{
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} rsm_sfr_req_t;
	typedef enum logic [1:0] {LS_IDLE, LS_LOW, LS_HIGH} rsm_link_st_t;
endpackage

// file: rtl/rsm_fifo2.sv
// small first-in first-out buffer with valid and ready on both sides
module rsm_fifo2
	import rsm_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 2
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(D);
	localparam logic [AW-1:0] LAST = AW'(D - 1);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;
	assign in_ready = (cnt != FULL);
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp] <= in_data;
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end
		else
		begin
			if (push)
				wp <= (wp == LAST) ? '0 : wp + 1'b1;
			if (pop)
				rp <= (rp == LAST) ? '0 : rp + 1'b1;
			if (push && !pop)
				cnt <= cnt + 1'b1;
			else if (pop && !push)
				cnt <= cnt - 1'b1;
		end
	end
endmodule

// file: rtl/rsm_link.sv
// serial shift engine on the link clock, one byte per request toggle
module rsm_link
	import rsm_pkg::*;
(
	input wire logic link_clk,
	input wire logic nrst,
	input wire logic req_tgl,
	input wire logic [7:0] tx_byte,
	output logic ack_tgl,
	output logic [7:0] rx_byte,
	output logic sck,
	output logic mosi,
	input wire logic miso
);
	rsm_link_st_t st;
	logic s1;
	logic s2;
	logic s3;
	logic seen;
	logic pending;
	logic [7:0] sh;
	logic [7:0] rx_sh;
	logic [2:0] bitc;
	// a request counts only once the second and third stage agree
	assign pending = (s2 == s3) && (s3 != seen);
	always_ff @(posedge link_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= req_tgl;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// tx_byte is held steady by the sender until the answer toggles back
	always_ff @(posedge link_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= LS_IDLE;
			seen <= 1'b0;
			sh <= 8'h00;
			rx_sh <= 8'h00;
			rx_byte <= 8'h00;
			bitc <= 3'h0;
			ack_tgl <= 1'b0;
			sck <= 1'b0;
			mosi <= 1'b0;
		end
		else
		begin
			unique case (st)
				LS_IDLE:
				begin
					if (pending)
					begin
						seen <= s3;
						sh <= tx_byte;
						mosi <= tx_byte[7];
						bitc <= 3'h0;
						st <= LS_LOW;
					end
				end
				LS_LOW:
				begin
					sck <= 1'b1;
					rx_sh <= {rx_sh[6:0], miso};
					st <= LS_HIGH;
				end
				LS_HIGH:
				begin
					sck <= 1'b0;
					if (bitc == 3'h7)
					begin
						rx_byte <= rx_sh;
						ack_tgl <= ~ack_tgl;
						st <= LS_IDLE;
					end
					else
					begin
						sh <= {sh[6:0], 1'b0};
						mosi <= sh[6];
						bitc <= bitc + 3'h1;
						st <= LS_LOW;
					end
				end
			endcase
		end
	end
endmodule

// file: dv/rsm_radio_model.sv
// behavioural radio serial slave facing the master
module rsm_radio_model
#(
	parameter logic [7:0] STATUS = 8'h0E
)
(
	input wire logic sck,
	input wire logic mosi,
	input wire logic radio_chip_select_n,
	output logic miso
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_sh = 8'h00;
	logic [7:0] rx_sh = 8'h00;
	logic [7:0] got [$];
	int bits = 0;
	initial miso = 1'b0;
	// ************
	// frame logic
	// ************
	always @(negedge radio_chip_select_n)
	begin
		bits = 0;
		tx_sh = STATUS;
		miso = tx_sh[7];
	end
	// no pull on the line: a released line must not keep its value
	always @(posedge radio_chip_select_n)
		miso = ~miso;
	always @(posedge sck)
		if (!radio_chip_select_n)
		begin
			rx_sh = {rx_sh[6:0], mosi};
			bits++;
			if (bits == 8)
			begin
				got.push_back(rx_sh);
				// echo one byte late, so pairing shows at the master
				tx_sh = rx_sh;
				bits = 0;
			end
		end
	always @(negedge sck)
		if (!radio_chip_select_n)
		begin
			if (bits != 0)
				tx_sh = {tx_sh[6:0], 1'b0};
			miso = tx_sh[7];
		end
endmodule

// file: dv/rsm_top_tb.sv
// self-checking bench for the radio serial master
`include "rsm_defs.svh"
module rsm_top_tb
	import rsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic lclk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, v;
	logic irq, sck, mosi, miso, csn_n, ce, radio_clock_enable_pin;
	logic [7:0] sent [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	// link clock unrelated in phase to the system clock
	initial #13 forever #40 lclk = ~lclk;
	rsm_top i_rsm_top (.REF_CLK(clk), .NRST(nrst), .LINK_CLK(lclk),
		.SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata),
		.SFR_RDATA(rdata), .IRQ(irq), .RADIO_SCK(sck),
		.RADIO_MOSI(mosi), .RADIO_MISO(miso),
		.RADIO_CHIP_SELECT_N(csn_n), .RADIO_CHIP_ENABLE(ce),
		.RADIO_CLOCK_ENABLE_PIN(radio_clock_enable_pin));
	rsm_radio_model #(.STATUS(8'h0E)) i_rsm_radio_model (.sck(sck),
		.mosi(mosi), .radio_chip_select_n(csn_n), .miso(miso));
	// ************
	// access tasks
	// ************
	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk) #1;
		wr = 1'b0;
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [7:0] e);
		@(posedge clk) #1;
		addr = a;
		rd = 1'b1;
		@(posedge clk) #1;
		rd = 1'b0;
		v = rdata;
		if (what != "")
			chk(what, e, v);
	endtask
	// polls the flags, bounded, then compares
	task automatic wait_flags(input logic [7:0] e);
		rd_chk("", `RSM_ADDR_FLAGS, e);
		for (int i = 0; i < 3000 && v !== e; i++)
			rd_chk("", `RSM_ADDR_FLAGS, e);
		chk("flags", e, v);
	endtask
	task automatic close_out;
		$display("checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			close_out();
		end
	end
	// ************
	// main sequence
	// ************
	initial
	begin
		// both domains need edges while in reset
		repeat (8) @(posedge lclk);
		@(posedge clk) #1;
		nrst = 1'b1;
		rd_chk("cfg", `RSM_ADDR_CFG, 8'h01);
		rd_chk("mask", `RSM_ADDR_MASK, 8'h0F);
		rd_chk("flags", `RSM_ADDR_FLAGS, 8'h03);
		rd_chk("data", `RSM_ADDR_DATA, 8'h00);
		rd_chk("control", `RSM_ADDR_CON, 8'h02);
		rd_chk("unmapped", 8'hE0, 8'h00);
		chk("pins", 8'h02, {5'h00, radio_clock_enable_pin, csn_n, ce});
		sfr_wr(`RSM_ADDR_FLAGS, 8'h00);
		rd_chk("flags", `RSM_ADDR_FLAGS, 8'h03);
		sfr_wr(`RSM_ADDR_MASK, 8'hFF);
		rd_chk("mask", `RSM_ADDR_MASK, 8'h0F);
		chk("irq", 8'h00, {7'h00, irq});
		sfr_wr(`RSM_ADDR_MASK, 8'h0E);
		repeat (2) @(posedge clk) #1;
		chk("irq", 8'h01, {7'h00, irq});
		sfr_wr(`RSM_ADDR_MASK, 8'h07);
		repeat (2) @(posedge clk) #1;
		chk("irq", 8'h00, {7'h00, irq});
		sfr_wr(`RSM_ADDR_CON, 8'hFD);
		@(posedge clk) #1;
		chk("pins", 8'h05, {5'h00, radio_clock_enable_pin, csn_n, ce});
		rd_chk("control", `RSM_ADDR_CON, 8'h05);
		sfr_wr(`RSM_ADDR_DATA, sent[0]);
		sfr_wr(`RSM_ADDR_DATA, sent[1]);
		wait_flags(8'h0F);
		@(posedge clk) #1;
		chk("irq", 8'h01, {7'h00, irq});
		sfr_wr(`RSM_ADDR_DATA, sent[2]);
		sfr_wr(`RSM_ADDR_DATA, sent[3]);
		rd_chk("flags", `RSM_ADDR_FLAGS, 8'h0C);
		repeat (1000) @(posedge clk);
		chk("stall", 8'h02, 8'(i_rsm_radio_model.got.size()));
		rd_chk("status", `RSM_ADDR_DATA, 8'h0E);
		wait_flags(8'h0D);
		rd_chk("echo", `RSM_ADDR_DATA, sent[0]);
		wait_flags(8'h0F);
		rd_chk("echo", `RSM_ADDR_DATA, sent[1]);
		rd_chk("flags", `RSM_ADDR_FLAGS, 8'h07);
		rd_chk("echo", `RSM_ADDR_DATA, sent[2]);
		rd_chk("flags", `RSM_ADDR_FLAGS, 8'h03);
		chk("irq", 8'h00, {7'h00, irq});
		rd_chk("empty", `RSM_ADDR_DATA, 8'h00);
		for (int i = 0; i < 4; i++)
			chk("mosi", sent[i], i_rsm_radio_model.got[i]);
		close_out();
	end
endmodule
